// ==== pkg/dbs_pkg.sv ====
// constants and types for the start/stop support block: dc braking,
// speed search and the general-purpose delay timer.
// assumes a single 200 MHz core clock and settings held outside as plain ports.
package dbs_pkg;

  // clock and tick timing
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned TICK_10MS_S100 = 1;            // 0.01 s, braking unit
  localparam int unsigned TICK_100MS_S10 = 1;            // 0.1 s, timer unit
  localparam int unsigned CYC_10MS       = CLK_HZ / 100 * TICK_10MS_S100;
  localparam int unsigned CYC_100MS      = CLK_HZ / 10 * TICK_100MS_S10;

  // settings after reset, limits and function codes
  localparam logic [6:0]  BRAKE_CUR_RST   = 7'h1E;   // 30 percent
  localparam logic [6:0]  BRAKE_CUR_KNEE  = 7'h1E;   // carrier drop above this
  localparam logic [6:0]  PCT_MAX         = 7'h64;   // 100 percent
  localparam logic [6:0]  SEARCH_CUR_RST  = 7'h50;   // 80 percent
  localparam logic [13:0] BRAKE_TIME_MAX  = 14'h270F; // 99.99 s in 0.01 s
  localparam logic [14:0] TIMER_DLY_MAX   = 15'h7530; // 3000.0 s in 0.1 s
  localparam logic [6:0]  BRAKE_FREQ_RST  = 7'h05;   // 0.5 Hz in 0.1 Hz
  localparam logic [6:0]  BRAKE_FREQ_MAX  = 7'h64;   // 10.0 Hz in 0.1 Hz
  localparam logic [7:0]  FUNC_TIMER_IN   = 8'h34;   // input function 52
  localparam logic [7:0]  FUNC_TIMER_OUT  = 8'h0F;   // output function 15

  // search start point selection
  localparam logic [2:0]  SEARCH_OFF      = 3'h0;
  localparam logic [2:0]  SEARCH_FROM_TOP = 3'h1;
  localparam logic [2:0]  SEARCH_FROM_CMD = 3'h2;

  typedef enum logic [2:0] {
    DBS_IDLE, DBS_START_BRAKE, DBS_SEARCH, DBS_RUN, DBS_STOP_BRAKE
  } dbs_state_t;

endpackage : dbs_pkg

// ==== hdl/dbs_core.sv ====
// start/stop support: dc braking at start and stop, current-type speed
// search, and an on/off delay timer between a digital input and output.
// assumes setting ports are static relative to the clock; run and terminal
// inputs arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
module dbs_core
  import dbs_pkg::*;
#(
  parameter int unsigned CYC_BRAKE_TICK = CYC_10MS,
  parameter int unsigned CYC_TIMER_TICK = CYC_100MS,
  parameter int unsigned FREQ_W         = 12
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // braking settings
  input  wire logic [6:0]        brake_start_freq,
  input  wire logic [6:0]        brake_current_pct,
  input  wire logic [13:0]       brake_time_at_start,
  input  wire logic [13:0]       brake_time_at_stop,
  input  wire logic [6:0]        min_output_freq,
  input  wire logic              stop_method_select,
  // speed search settings and feedback
  input  wire logic [2:0]        speed_search_select,
  input  wire logic [6:0]        speed_search_current_pct,
  input  wire logic [6:0]        measured_current_pct,
  input  wire logic [FREQ_W-1:0] output_freq,
  input  wire logic [FREQ_W-1:0] max_freq,
  input  wire logic [FREQ_W-1:0] freq_command,
  // run command, asynchronous
  input  wire logic              run_cmd,
  // timer terminals
  input  wire logic [7:0]        input_terminal_function,
  input  wire logic [7:0]        output_terminal_function,
  input  wire logic              digital_input_terminal,
  input  wire logic [14:0]       timer_on_delay,
  input  wire logic [14:0]       timer_off_delay,
  // drive-side outputs
  output logic                   dc_brake_active,
  output logic [6:0]             dc_brake_level,
  output logic                   carrier_low,
  output logic                   search_active,
  output logic [FREQ_W-1:0]      search_freq,
  output logic                   search_done,
  output logic                   output_enable,
  output logic                   relay_output_terminal,
  output logic                   timer_active
);

  ////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    logic [1:0]        run_sync;
    logic [1:0]        tin_sync;
    logic [31:0]       brk_div;
    logic [31:0]       tmr_div;
    dbs_state_t        state;
    logic [13:0]       brk_cnt;
    logic [FREQ_W-1:0] sfreq;
    logic              sdone;
    logic              tin_last;
    logic [14:0]       tmr_cnt;
    logic              tout;
    logic              brake_on;
    logic [6:0]        blevel;
    logic              carr_low;
  } dbs_reg_t;

  dbs_reg_t r;
  dbs_reg_t next_r;

  // percentage clipped to 100
  function automatic logic [6:0] dbs_clip_pct(input logic [6:0] v);
    dbs_clip_pct = (v > PCT_MAX) ? PCT_MAX : v;
  endfunction : dbs_clip_pct

  ////////////////////////////////////////////////////////////////////////
  logic              run_s;
  logic              tin_s;
  logic              brk_tick;
  logic              tmr_tick;
  logic              tmr_enabled;
  logic [6:0]        eff_start_freq;
  logic [6:0]        cur_thr;

  assign run_s    = r.run_sync[1];
  assign tin_s    = r.tin_sync[1];
  assign brk_tick = (r.brk_div == CYC_BRAKE_TICK - 1);
  assign tmr_tick = (r.tmr_div == CYC_TIMER_TICK - 1);
  assign cur_thr  = dbs_clip_pct(speed_search_current_pct);
  assign tmr_enabled = (input_terminal_function == FUNC_TIMER_IN) &&
                       (output_terminal_function == FUNC_TIMER_OUT);
  assign eff_start_freq = (brake_start_freq < min_output_freq) ? min_output_freq
                        : ((brake_start_freq > BRAKE_FREQ_MAX) ? BRAKE_FREQ_MAX
                                                               : brake_start_freq);

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_r = r;
    // two-flop synchronisers, first stage read only by the second
    next_r.run_sync = {r.run_sync[0], run_cmd};
    next_r.tin_sync = {r.tin_sync[0], digital_input_terminal};
    // free-running tick dividers
    next_r.brk_div = brk_tick ? 32'h0 : r.brk_div + 32'h1;
    next_r.tmr_div = tmr_tick ? 32'h0 : r.tmr_div + 32'h1;

    next_r.blevel   = dbs_clip_pct(brake_current_pct);
    next_r.carr_low = (dbs_clip_pct(brake_current_pct) > BRAKE_CUR_KNEE);

    unique case (r.state)
      DBS_IDLE: begin
        next_r.brake_on = 1'b0;
        if (run_s) begin
          next_r.brk_cnt = 14'h0;
          next_r.sdone   = 1'b0;
          if (brake_time_at_start != 14'h0) begin
            next_r.state    = DBS_START_BRAKE;
            next_r.brake_on = 1'b1;
          end else if (speed_search_select == SEARCH_FROM_TOP ||
                       speed_search_select == SEARCH_FROM_CMD) begin
            next_r.state = DBS_SEARCH;
            next_r.sfreq = (speed_search_select == SEARCH_FROM_TOP) ? max_freq
                                                                    : freq_command;
          end else begin
            next_r.state = DBS_RUN;
          end
        end
      end
      DBS_START_BRAKE: begin
        // timed start braking in 0.01 s ticks
        if (brk_tick)
          next_r.brk_cnt = r.brk_cnt + 14'h1;
        if (!run_s) begin
          next_r.state    = DBS_IDLE;
          next_r.brake_on = 1'b0;
        end else if (r.brk_cnt >= brake_time_at_start ||
                     r.brk_cnt >= BRAKE_TIME_MAX) begin
          next_r.brake_on = 1'b0;
          next_r.state    = DBS_RUN;   // motor held still, no search needed
        end
      end
      DBS_SEARCH: begin
        // search ends when current drops below threshold
        if (!run_s) begin
          next_r.state = DBS_IDLE;
        end else if (measured_current_pct < cur_thr) begin
          next_r.sdone = 1'b1;
          next_r.state = DBS_RUN;
        end else if (brk_tick && r.sfreq != '0) begin
          next_r.sfreq = r.sfreq - {{(FREQ_W-1){1'b0}}, 1'b1};
        end
      end
      DBS_RUN: begin
        // ramp stop braking below start frequency
        if (!run_s) begin
          next_r.brk_cnt = 14'h0;
          if (stop_method_select)
            next_r.state = DBS_IDLE;            // coast: no stop braking
          else if (output_freq < FREQ_W'(eff_start_freq)) begin
            if (brake_time_at_stop != 14'h0) begin
              next_r.state    = DBS_STOP_BRAKE;
              next_r.brake_on = 1'b1;
            end else begin
              next_r.state = DBS_IDLE;
            end
          end
        end
      end
      DBS_STOP_BRAKE: begin
        if (brk_tick)
          next_r.brk_cnt = r.brk_cnt + 14'h1;
        if (run_s || r.brk_cnt >= brake_time_at_stop ||
            r.brk_cnt >= BRAKE_TIME_MAX) begin
          next_r.brake_on = 1'b0;
          next_r.state    = DBS_IDLE;
        end
      end
    endcase

    // timer counts ticks, restart on input change
    next_r.tin_last = tin_s;
    if (!tmr_enabled) begin
      next_r.tmr_cnt = 15'h0;
      next_r.tout    = 1'b0;
    end else if (tin_s != r.tin_last) begin
      next_r.tmr_cnt = 15'h0;
    end else if (tin_s != r.tout) begin
      // on-delay, off-delay; zero delay switches at once
      if (r.tmr_cnt >= (tin_s ? timer_on_delay : timer_off_delay) ||
          r.tmr_cnt >= TIMER_DLY_MAX) begin
        next_r.tout    = tin_s;
        next_r.tmr_cnt = 15'h0;
      end else if (tmr_tick) begin
        next_r.tmr_cnt = r.tmr_cnt + 15'h1;
      end
    end else begin
      next_r.tmr_cnt = 15'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.state    <= DBS_IDLE;
      r.blevel   <= BRAKE_CUR_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flops except search_active, output_enable and timer_active
  assign dc_brake_active       = r.brake_on;
  assign dc_brake_level        = r.blevel;
  assign carrier_low           = r.carr_low;
  assign search_active         = (r.state == DBS_SEARCH);
  assign search_freq           = r.sfreq;
  assign search_done           = r.sdone;
  assign output_enable         = (r.state != DBS_IDLE);
  assign relay_output_terminal = r.tout;
  assign timer_active          = tmr_enabled;

endmodule : dbs_core

// ==== testbench/dbs_monitor.sv ====
// checker for the start/stop support block, on top-level ports only
// assumes the bind at the foot of this file and one core clock domain
`timescale 1ns/1ps
module dbs_monitor
  import dbs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [6:0]  brake_current_pct,
  input wire logic [13:0] brake_time_at_start,
  input wire logic [2:0]  speed_search_select,
  input wire logic        run_cmd,
  input wire logic [7:0]  input_terminal_function,
  input wire logic [7:0]  output_terminal_function,
  input wire logic        digital_input_terminal,
  input wire logic        dc_brake_active,
  input wire logic [6:0]  dc_brake_level,
  input wire logic        carrier_low,
  input wire logic        search_active,
  input wire logic        output_enable,
  input wire logic        relay_output_terminal,
  input wire logic        timer_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_level; $past(rst_n) |-> dc_brake_level == ($past(brake_current_pct) > PCT_MAX ?
    PCT_MAX : $past(brake_current_pct)); endproperty
  a_level: assert property (p_level)
    else $error("braking level off");
  property p_carrier; $past(rst_n) |-> carrier_low == ($past(brake_current_pct) > BRAKE_CUR_KNEE);
  endproperty
  a_carrier: assert property (p_carrier)
    else $error("carrier drop off");
  property p_start_brake; $rose(run_cmd) && brake_time_at_start != 14'h0000 && !output_enable
    |-> ##[1:4] dc_brake_active; endproperty
  a_start_brake: assert property (p_start_brake)
    else $error("no braking at start");
  property p_no_brake; $rose(run_cmd) && brake_time_at_start == 14'h0000 && !output_enable &&
    speed_search_select == SEARCH_OFF |-> ##[1:4] (output_enable && !dc_brake_active); endproperty
  a_no_brake: assert property (p_no_brake)
    else $error("start without braking failed");
  property p_search_en; search_active |-> output_enable && !dc_brake_active; endproperty
  a_search_en: assert property (p_search_en)
    else $error("output off during search");
  property p_gate; timer_active == (input_terminal_function == FUNC_TIMER_IN &&
    output_terminal_function == FUNC_TIMER_OUT); endproperty
  a_gate: assert property (p_gate)
    else $error("timer gate wrong");
  property p_idle_relay; !timer_active [*2] |-> !relay_output_terminal; endproperty
  a_idle_relay: assert property (p_idle_relay)
    else $error("relay on with timer off");
  property p_relay_on; $rose(relay_output_terminal) |-> $past(digital_input_terminal, 3);
  endproperty
  a_relay_on: assert property (p_relay_on)
    else $error("relay on with input open");
  property p_relay_off; $fell(relay_output_terminal) && timer_active
    |-> !$past(digital_input_terminal, 3); endproperty
  a_relay_off: assert property (p_relay_off)
    else $error("relay off with input closed");
endmodule : dbs_monitor
bind dbs_core dbs_monitor dbs_monitor_i (.core_clk, .rst_n, .brake_current_pct,
  .brake_time_at_start, .speed_search_select, .run_cmd, .input_terminal_function,
  .output_terminal_function, .digital_input_terminal, .dc_brake_active, .dc_brake_level,
  .carrier_low, .search_active, .output_enable, .relay_output_terminal, .timer_active);

// ==== testbench/dbs_motor_model.sv ====
// coasting motor as seen through the current feedback
// assumes search_freq and coast_freq share the 0.1 Hz unit
`timescale 1ns/1ps
module dbs_motor_model #(
  parameter int unsigned FREQ_W = 12
) (
  input  wire logic [FREQ_W-1:0] search_freq,
  input  wire logic              search_active,
  input  wire logic [FREQ_W-1:0] coast_freq,
  output logic      [6:0]        measured_current_pct
);
  // current stays high while the search is above the rotor
  assign measured_current_pct = (search_active && search_freq > coast_freq) ? 7'h5A : 7'h14;
endmodule : dbs_motor_model

// ==== testbench/tb_drive_brake_search_timer.sv ====
// bench for the start/stop support block with a coasting motor model
// assumes short tick parameters: 4 cycles braking, 8 cycles timer
`timescale 1ns/1ps
module tb_drive_brake_search_timer;
  import dbs_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, stop_method_select = 1'b0, run_cmd = 1'b0;
  logic digital_input_terminal = 1'b0;
  logic [6:0] brake_start_freq = 7'h05, brake_current_pct = 7'h1E, min_output_freq = 7'h00;
  logic [6:0] speed_search_current_pct = 7'h32, measured_current_pct, dc_brake_level;
  logic [13:0] brake_time_at_start = 14'h0003, brake_time_at_stop = 14'h0004;
  logic [2:0] speed_search_select = 3'h0;
  logic [11:0] output_freq = 12'h00A, max_freq = 12'h064, freq_command = 12'h050;
  logic [11:0] coast_freq = 12'h03C, search_freq;
  logic [7:0] input_terminal_function = 8'h34, output_terminal_function = 8'h0F;
  logic [14:0] timer_on_delay = 15'h0003, timer_off_delay = 15'h0002;
  logic dc_brake_active, carrier_low, search_active, search_done, output_enable;
  logic relay_output_terminal, timer_active;
  int miscompares = 0, comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  dbs_core #(.CYC_BRAKE_TICK(4), .CYC_TIMER_TICK(8)) dbs_core_i (.core_clk, .rst_n,
    .brake_start_freq, .brake_current_pct, .brake_time_at_start, .brake_time_at_stop,
    .min_output_freq, .stop_method_select, .speed_search_select, .speed_search_current_pct,
    .measured_current_pct, .output_freq, .max_freq, .freq_command, .run_cmd,
    .input_terminal_function, .output_terminal_function, .digital_input_terminal,
    .timer_on_delay, .timer_off_delay, .dc_brake_active, .dc_brake_level, .carrier_low,
    .search_active, .search_freq, .search_done, .output_enable, .relay_output_terminal,
    .timer_active);
  dbs_motor_model #(.FREQ_W(12)) dbs_motor_model_i (.search_freq, .search_active, .coast_freq,
    .measured_current_pct);
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // watchdog well beyond the few hundred cycles of the tests
  initial begin
    #50000;
    miscompares++;
    complete_run();
  end
  initial begin
    cyc(8);
    chk("reset level", dc_brake_level, 16'h001E);
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    chk("carrier 30", carrier_low, 16'h0000);
    brake_current_pct = 7'h1F;
    cyc(2);
    chk("carrier 31", carrier_low, 16'h0001);
    brake_current_pct = 7'h7F;
    cyc(2);
    chk("level clip", dc_brake_level, 16'h0064);
    // on-delay, a short bounce, then off-delay
    digital_input_terminal = 1'b1;
    cyc(12);
    chk("early on", relay_output_terminal, 16'h0000);
    cyc(30);
    chk("on", relay_output_terminal, 16'h0001);
    digital_input_terminal = 1'b0;
    cyc(6);
    digital_input_terminal = 1'b1;
    cyc(30);
    chk("bounce", relay_output_terminal, 16'h0001);
    digital_input_terminal = 1'b0;
    cyc(8);
    chk("early off", relay_output_terminal, 16'h0001);
    cyc(30);
    chk("off", relay_output_terminal, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      {input_terminal_function, output_terminal_function} = k ? 16'h340E : 16'h330F;
      digital_input_terminal = ~digital_input_terminal;
      cyc(40);
      chk("gate relay", relay_output_terminal, 16'h0000);
      chk("gate", timer_active, 16'h0000);
    end
    // braking at start, then at stop held off until below the minimum
    run_cmd = 1'b1;
    cyc(5);
    chk("start brake", dc_brake_active, 16'h0001);
    cyc(20);
    chk("start brake end", dc_brake_active, 16'h0000);
    min_output_freq = 7'h08;
    run_cmd = 1'b0;
    cyc(6);
    chk("above start freq", dc_brake_active, 16'h0000);
    output_freq = 12'h007;
    cyc(6);
    chk("min freq brake", dc_brake_active, 16'h0001);
    cyc(25);
    chk("stop brake end", output_enable, 16'h0000);
    // search codes 0 to 4 on a coasting motor
    brake_time_at_start = 14'h0000;
    stop_method_select = 1'b1;
    for (int s = 0; s < 5; s++) begin
      speed_search_select = 3'(s);
      run_cmd = 1'b1;
      cyc(6);
      chk("search on", search_active, 16'((s == 1) || (s == 2)));
      if (s == 1 || s == 2) chk("from", 16'((s == 1 ? 12'h064 : 12'h050) - search_freq < 3), 16'h1);
      for (int k = 0; k < 600 && search_active === 1'b1; k++) cyc(1);
      chk("search end", search_done, 16'((s == 1) || (s == 2)));
      if (s == 1 || s == 2) chk("catch", 16'(coast_freq - search_freq < 3), 16'h1);
      chk("no stop", output_enable, 16'h0001);
      run_cmd = 1'b0;
      cyc(8);
    end
    complete_run();
  end
endmodule : tb_drive_brake_search_timer
